/* File: oda_defines.vh */
// Purpose: constants for the object dictionary access engine
// Assumes: 32-bit apb data, one word per register
// Notes: offsets are byte addresses
`ifndef ODA_DEFINES_VH
`define ODA_DEFINES_VH
`define ODA_ERR_ACCESS 8'h01
`define ODA_ERR_FORMAT 8'h02
`define ODA_ERR_MISSING 8'h04
`define ODA_IDX_NOP 16'h0000
`define ODA_DYN_LO 16'h5100
`define ODA_DYN_HI 16'h57FF
`define ODA_DYN_BASE 16'h5100
`define ODA_CHTYPE_IDX 16'h5001
`define ODA_NUM_CH 6
`define ODA_OBJ_RW 2'h0
`define ODA_OBJ_RO 2'h1
`define ODA_OBJ_WO 2'h2
`define ODA_FMT_8 2'h0
`define ODA_FMT_16 2'h1
`define ODA_FMT_32 2'h2
`define ODA_FMT_WIDE 2'h3
`define ODA_A_STATUS 12'h000
`define ODA_A_CLEAR 12'h004
`define ODA_A_ENABLE 12'h008
`define ODA_A_CHMAP 12'h00C
`define ODA_A_RDCNT 12'h010
`define ODA_A_WRCNT 12'h014
`define ODA_EV_RD 0
`define ODA_EV_WR 1
`define ODA_EV_ERR 2
`define ODA_EV_NOP 3
`define ODA_NUM_EV 4
`endif

/* File: oda_engine.v */
// Purpose: object dictionary read/write request engine fed by cyclic container fields
// Assumes: request fields arrive on i_clk with i_cyc_update marking each cyclic refresh;
//          object store lives outside, reached by a one-cycle lookup port
// Notes: apb slave holds interrupt status, enable, clear and channel map
//        read and write counters count every access, errors included
//
// Notes on behaviour
// [RULE1] act only when index, subindex, filler or value differ from last request
// [RULE2] index zero is a no-op; nothing is read or written
// [RULE3] index zero clears the matching response fields to zero
// [RULE4] controller changes a field to repeat an identical request
// [RULE5] read response echoes index/subindex actually read; valid when matched, no error
// [RULE6] error codes 0x01 access, 0x02 format, 0x04 missing object
// [RULE7] write response echoes written index/subindex; success when matched, no error
// [RULE8] index is 16 bits, subindex 8 bits, full ranges
// [RULE9] value field: 32, 16 or 8 bit objects right aligned, upper bits unused
// [RULE10] only objects up to 32 bits are reachable
// [RULE11] float values pass as raw bit patterns, never converted
// [RULE12] controller sets index zero, loads subindex and value, then index
// [RULE13] writes store the value with no range checking
// [RULE14] action commands still carry a value, for example zero
// [RULE15] dynamic indices exist only while their calculated channel exists
// [RULE16] channel block object index is dynamic base plus block position
// [RULE17] each object has an access attribute; read-only writes return access error
// [RULE18] writing type codes to channel type subindices 1..6 creates channels
// [RULE19] last request of each container is kept and compared every cyclic update
`timescale 1ns/100ps
`default_nettype none
`include "oda_defines.vh"

module oda_engine #(
    parameter NUM_CH = `ODA_NUM_CH
) (
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_cyc_update,
    input wire [15:0] i_rd_index,
    input wire [7:0] i_rd_object_subindex,
    input wire [7:0] i_rd_filler,
    input wire [15:0] i_wr_index,
    input wire [7:0] i_wr_object_subindex,
    input wire [7:0] i_wr_filler,
    input wire [31:0] i_wr_value,
    output reg [15:0] o_rd_resp_index,
    output reg [7:0] o_rd_resp_object_subindex,
    output reg [7:0] o_rd_resp_error,
    output reg [31:0] o_rd_resp_value,
    output reg [15:0] o_wr_resp_index,
    output reg [7:0] o_wr_resp_object_subindex,
    output reg [7:0] o_wr_resp_error,
    output wire [15:0] o_obj_index,
    output wire [7:0] o_obj_object_subindex,
    output reg o_obj_rd,
    output reg o_obj_wr,
    output reg [31:0] o_obj_wdata,
    input wire i_obj_exists,
    input wire [1:0] i_obj_access,
    input wire [1:0] i_obj_format,
    input wire [31:0] i_obj_rdata,
    output wire [NUM_CH-1:0] o_ch_present,
    input wire [11:0] i_paddr,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr,
    output wire o_irq
);

    // two-step engine: a request is latched, then looked up one cycle later;
    // the idle cycle between lets a changing field settle before it is used,
    // at the cost of one cycle of answer latency
    localparam ST_IDLE = 2'h0;
    localparam ST_RD = 2'h1;
    localparam ST_WR = 2'h2;

    reg [1:0] state_reg;
    reg [39:0] rd_last_reg;
    reg [63:0] wr_last_reg;
    reg rd_pend_reg;
    reg wr_pend_reg;
    reg [15:0] cur_idx_reg;
    reg [7:0] cur_sub_reg;
    reg [7:0] ch_type_reg [0:NUM_CH-1];
    reg [NUM_CH-1:0] ch_map_reg;
    reg [`ODA_NUM_EV-1:0] ev_status_reg;
    reg [`ODA_NUM_EV-1:0] ev_enable_reg;
    reg [`ODA_NUM_EV-1:0] ev_set;
    reg [31:0] rd_cnt_reg;
    reg [31:0] wr_cnt_reg;
    reg [7:0] err_next;
    reg local_hit;
    reg [31:0] local_data;
    reg [2:0] ch_sel;

    wire [39:0] rd_now;
    wire [63:0] wr_now;
    wire rd_changed;
    wire wr_changed;
    wire dyn_range;
    wire [15:0] dyn_pos;
    wire dyn_live;
    wire chtype_obj;
    wire apb_wr;
    wire apb_rd;

    // request snapshots, the filler byte counts as a field too
    // the read container has no value field, so its low byte is padded
    assign rd_now = {i_rd_index, i_rd_object_subindex, i_rd_filler, 8'h00};
    assign wr_now = {i_wr_index, i_wr_object_subindex, i_wr_filler, i_wr_value};
    assign rd_changed = i_cyc_update && (rd_now != rd_last_reg); // [RULE1] [RULE19]
    assign wr_changed = i_cyc_update && (wr_now != wr_last_reg); // [RULE1] [RULE19]

    // per-channel presence: a nonzero type code makes the channel live
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
            assign o_ch_present[g] = (ch_type_reg[g] != 8'h00); // [RULE18]
        end
    endgenerate

    // dynamic range decode, position counted from the base
    // positions beyond NUM_CH never exist, whatever the store claims;
    // the bit-select below is only reached when the position is in range
    assign dyn_range = (cur_idx_reg >= `ODA_DYN_LO) && (cur_idx_reg <= `ODA_DYN_HI);
    assign dyn_pos = cur_idx_reg - `ODA_DYN_BASE; // [RULE16]
    assign dyn_live = (dyn_pos >= 16'h0001) && (dyn_pos <= NUM_CH)
        && o_ch_present[dyn_pos[2:0] - 3'h1]; // [RULE15]
    assign chtype_obj = (cur_idx_reg == `ODA_CHTYPE_IDX)
        && (cur_sub_reg >= 8'h01) && (cur_sub_reg <= NUM_CH);

    assign o_obj_index = cur_idx_reg;
    assign o_obj_object_subindex = cur_sub_reg;

    // lookup: channel type objects live here, the rest outside
    always @* begin
        ch_sel = cur_sub_reg[2:0] - 3'h1;
        local_hit = chtype_obj;
        local_data = {24'h000000, ch_type_reg[ch_sel]};
    end

    // error classification; dynamic objects of absent channels do not exist
    // order matters: a missing object hides format and access faults,
    // so the controller sees one code, never an or of several
    always @* begin
        err_next = 8'h00;
        if (!local_hit) begin
            if (!i_obj_exists || (dyn_range && !dyn_live)) begin
                err_next = `ODA_ERR_MISSING; // [RULE6] [RULE15]
            end else if (i_obj_format == `ODA_FMT_WIDE) begin
                err_next = `ODA_ERR_FORMAT; // [RULE10] [RULE6]
            end else if (state_reg == ST_WR && i_obj_access == `ODA_OBJ_RO) begin
                err_next = `ODA_ERR_ACCESS; // [RULE17] [RULE6]
            end else if (state_reg == ST_RD && i_obj_access == `ODA_OBJ_WO) begin
                err_next = `ODA_ERR_ACCESS; // [RULE17]
            end
        end
    end

    // event set pulses for the interrupt status
    // no-op events come straight from the snapshot compare, not the engine
    always @* begin
        ev_set = {`ODA_NUM_EV{1'b0}};
        ev_set[`ODA_EV_RD] = (state_reg == ST_RD);
        ev_set[`ODA_EV_WR] = (state_reg == ST_WR);
        ev_set[`ODA_EV_ERR] = (state_reg != ST_IDLE) && (err_next != 8'h00);
        ev_set[`ODA_EV_NOP] = (rd_changed && i_rd_index == `ODA_IDX_NOP)
            || (wr_changed && i_wr_index == `ODA_IDX_NOP);
    end

    // request engine: at most one read or write access every two cycles after a change
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_reg <= ST_IDLE;
            rd_last_reg <= 40'h0000000000;
            wr_last_reg <= 64'h0000000000000000;
            rd_pend_reg <= 1'b0;
            wr_pend_reg <= 1'b0;
            cur_idx_reg <= 16'h0000;
            cur_sub_reg <= 8'h00;
            o_rd_resp_index <= 16'h0000;
            o_rd_resp_object_subindex <= 8'h00;
            o_rd_resp_error <= 8'h00;
            o_rd_resp_value <= 32'h00000000;
            o_wr_resp_index <= 16'h0000;
            o_wr_resp_object_subindex <= 8'h00;
            o_wr_resp_error <= 8'h00;
            o_obj_rd <= 1'b0;
            o_obj_wr <= 1'b0;
            o_obj_wdata <= 32'h00000000;
            rd_cnt_reg <= 32'h00000000;
            wr_cnt_reg <= 32'h00000000;
        end else begin
            o_obj_wr <= 1'b0;
            o_obj_rd <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    // reads take precedence; a pending write waits one access
                    // the !changed guards keep a snapshot that moves this cycle
                    // from being used half old, half new
                    if (rd_pend_reg && !rd_changed) begin
                        cur_idx_reg <= rd_last_reg[39:24];
                        cur_sub_reg <= rd_last_reg[23:16];
                        rd_pend_reg <= 1'b0;
                        o_obj_rd <= 1'b1;
                        state_reg <= ST_RD;
                    end else if (wr_pend_reg && !wr_changed) begin
                        cur_idx_reg <= wr_last_reg[63:48];
                        cur_sub_reg <= wr_last_reg[47:40];
                        wr_pend_reg <= 1'b0;
                        state_reg <= ST_WR;
                    end
                end
                ST_RD: begin
                    o_rd_resp_index <= cur_idx_reg; // [RULE5] [RULE8]
                    o_rd_resp_object_subindex <= cur_sub_reg; // [RULE5]
                    o_rd_resp_error <= err_next; // [RULE5]
                    rd_cnt_reg <= rd_cnt_reg + 32'h00000001;
                    // narrow objects are zero extended so stale upper bits never leak
                    if (local_hit) begin
                        o_rd_resp_value <= local_data;
                    end else if (err_next != 8'h00) begin
                        o_rd_resp_value <= 32'h00000000;
                    end else if (i_obj_format == `ODA_FMT_8) begin
                        o_rd_resp_value <= {24'h000000, i_obj_rdata[7:0]}; // [RULE9]
                    end else if (i_obj_format == `ODA_FMT_16) begin
                        o_rd_resp_value <= {16'h0000, i_obj_rdata[15:0]}; // [RULE9]
                    end else begin
                        o_rd_resp_value <= i_obj_rdata; // [RULE11]
                    end
                    state_reg <= ST_IDLE;
                end
                ST_WR: begin
                    o_wr_resp_index <= cur_idx_reg; // [RULE7] [RULE8]
                    o_wr_resp_object_subindex <= cur_sub_reg; // [RULE7]
                    o_wr_resp_error <= err_next; // [RULE7]
                    wr_cnt_reg <= wr_cnt_reg + 32'h00000001;
                    // value goes through untouched, no range check
                    if (!local_hit && err_next == 8'h00) begin
                        o_obj_wr <= 1'b1; // [RULE13]
                        o_obj_wdata <= wr_last_reg[31:0]; // [RULE11] [RULE13]
                    end
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
            // snapshot every change; a zero index clears the response at once
            // kept below the case so a clear outranks a read finishing this cycle
            if (rd_changed) begin
                rd_last_reg <= rd_now; // [RULE19]
                if (i_rd_index == `ODA_IDX_NOP) begin
                    rd_pend_reg <= 1'b0; // [RULE2]
                    o_rd_resp_index <= 16'h0000; // [RULE3]
                    o_rd_resp_object_subindex <= 8'h00; // [RULE3]
                    o_rd_resp_error <= 8'h00; // [RULE3]
                    o_rd_resp_value <= 32'h00000000; // [RULE3]
                end else begin
                    rd_pend_reg <= 1'b1; // [RULE1]
                end
            end
            if (wr_changed) begin
                wr_last_reg <= wr_now; // [RULE19]
                if (i_wr_index == `ODA_IDX_NOP) begin
                    wr_pend_reg <= 1'b0; // [RULE2]
                    o_wr_resp_index <= 16'h0000; // [RULE3]
                    o_wr_resp_object_subindex <= 8'h00; // [RULE3]
                    o_wr_resp_error <= 8'h00; // [RULE3]
                end else begin
                    wr_pend_reg <= 1'b1; // [RULE1]
                end
            end
        end
    end

    // channel type objects: a write creates or removes the channel
    // clearing a type code removes the channel and its dynamic objects;
    // the outside store never sees these writes
    integer k;
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            for (k = 0; k < NUM_CH; k = k + 1) begin
                ch_type_reg[k] <= 8'h00;
            end
        end else if (state_reg == ST_WR && local_hit) begin
            ch_type_reg[ch_sel] <= wr_last_reg[7:0]; // [RULE18]
        end
    end

    // apb: zero wait states, unmapped reads return zero
    // limitation: writes to read-only offsets are dropped without pslverr
    assign o_pready = 1'b1;
    assign o_pslverr = 1'b0;
    assign apb_wr = i_psel && i_penable && i_pwrite;
    assign apb_rd = i_psel && !i_pwrite;

    // sticky status; a set in the clear cycle wins so no event is lost
    // the clear register reads back as zero; only enable reads back
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            ev_status_reg <= {`ODA_NUM_EV{1'b0}};
            ev_enable_reg <= {`ODA_NUM_EV{1'b0}};
            ch_map_reg <= {NUM_CH{1'b0}};
        end else begin
            if (apb_wr && i_paddr == `ODA_A_CLEAR) begin
                ev_status_reg <= (ev_status_reg & ~i_pwdata[`ODA_NUM_EV-1:0]) | ev_set;
            end else begin
                ev_status_reg <= ev_status_reg | ev_set;
            end
            if (apb_wr && i_paddr == `ODA_A_ENABLE) begin
                ev_enable_reg <= i_pwdata[`ODA_NUM_EV-1:0];
            end
            ch_map_reg <= o_ch_present;
        end
    end

    // read data registered at setup so it is stable in the access phase
    // counters wrap silently; software compares differences, not values
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_prdata <= 32'h00000000;
        end else if (apb_rd && !i_penable) begin
            case (i_paddr)
                `ODA_A_STATUS: o_prdata <= {{(32-`ODA_NUM_EV){1'b0}}, ev_status_reg};
                `ODA_A_ENABLE: o_prdata <= {{(32-`ODA_NUM_EV){1'b0}}, ev_enable_reg};
                `ODA_A_CHMAP: o_prdata <= {{(32-NUM_CH){1'b0}}, ch_map_reg};
                `ODA_A_RDCNT: o_prdata <= rd_cnt_reg;
                `ODA_A_WRCNT: o_prdata <= wr_cnt_reg;
                default: o_prdata <= 32'h00000000;
            endcase
        end
    end

    // level output, drops as soon as software clears or masks the cause
    assign o_irq = |(ev_status_reg & ev_enable_reg);

endmodule // oda_engine
`default_nettype wire

/* File: oda_engine_checker.sv */
// Purpose: port-level assertions for the object dictionary access engine
// Assumes: one clock, synchronous active-high reset
// Notes: bound to oda_engine below the module
`timescale 1ns/100ps
`default_nettype none
`include "oda_defines.vh"
module oda_engine_checker #(
    parameter NUM_CH = `ODA_NUM_CH
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_cyc_update,
    input wire logic [15:0] i_rd_index,
    input wire logic [31:0] i_wr_value,
    input wire logic [15:0] o_rd_resp_index,
    input wire logic [7:0] o_rd_resp_object_subindex,
    input wire logic [7:0] o_rd_resp_error,
    input wire logic [31:0] o_rd_resp_value,
    input wire logic [15:0] o_wr_resp_index,
    input wire logic [7:0] o_wr_resp_error,
    input wire logic [15:0] o_obj_index,
    input wire logic [7:0] o_obj_object_subindex,
    input wire logic o_obj_rd,
    input wire logic o_obj_wr,
    input wire logic [31:0] o_obj_wdata,
    input wire logic i_obj_exists,
    input wire logic [1:0] i_obj_access,
    input wire logic [1:0] i_obj_format,
    input wire logic [31:0] i_obj_rdata,
    input wire logic [NUM_CH-1:0] o_ch_present
);
    logic [7:0] rd_lo;
    // low byte of the store answer, for the alignment check
    assign rd_lo = i_obj_rdata[7:0];
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    property p_nop_clear;
        i_cyc_update && i_rd_index == 16'h0000 |=> o_rd_resp_index == 16'h0000
            && o_rd_resp_error == 8'h00 && o_rd_resp_value == 32'h0000_0000;
    endproperty
    a_nop_clear: assert property (p_nop_clear) else $error("index zero left response");
    property p_rd_cause;
        o_obj_rd |-> ($past(i_cyc_update) || $past(i_cyc_update, 2)) && o_obj_index != 16'h0000;
    endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("stray lookup");
    property p_rd_echo;
        o_obj_rd |=> o_rd_resp_index == $past(o_obj_index)
            && o_rd_resp_object_subindex == $past(o_obj_object_subindex);
    endproperty
    a_rd_echo: assert property (p_rd_echo) else $error("read response echo wrong");
    property p_rd_align;
        o_obj_rd && i_obj_exists && i_obj_format == `ODA_FMT_8 && i_obj_access != `ODA_OBJ_WO
            |=> o_rd_resp_value == {24'h00_0000, $past(rd_lo)};
    endproperty
    a_rd_align: assert property (p_rd_align) else $error("byte object misaligned");
    property p_wide;
        o_obj_rd && i_obj_exists && i_obj_format == `ODA_FMT_WIDE && i_obj_access != `ODA_OBJ_WO
            |=> o_rd_resp_error == `ODA_ERR_FORMAT;
    endproperty
    a_wide: assert property (p_wide) else $error("wide object not refused");
    property p_err_zero;
        o_rd_resp_error != 8'h00 |-> o_rd_resp_value == 32'h0000_0000;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error read carries value");
    property p_codes;
        o_rd_resp_error inside {8'h00, 8'h01, 8'h02, 8'h04}
            && o_wr_resp_error inside {8'h00, 8'h01, 8'h02, 8'h04};
    endproperty
    a_codes: assert property (p_codes) else $error("unknown error code");
    property p_wr_echo;
        o_obj_wr |-> o_wr_resp_error == 8'h00 && o_wr_resp_index == $past(o_obj_index)
            && o_wr_resp_index != 16'h0000 && o_obj_wdata == $past(i_wr_value, 2);
    endproperty
    a_wr_echo: assert property (p_wr_echo) else $error("store pulse wrong");
endmodule // oda_engine_checker
bind oda_engine oda_engine_checker #(.NUM_CH(NUM_CH)) u_chk (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_cyc_update(i_cyc_update), .i_rd_index(i_rd_index),
    .i_wr_value(i_wr_value), .o_rd_resp_index(o_rd_resp_index),
    .o_rd_resp_object_subindex(o_rd_resp_object_subindex), .o_rd_resp_error(o_rd_resp_error),
    .o_rd_resp_value(o_rd_resp_value), .o_wr_resp_index(o_wr_resp_index),
    .o_wr_resp_error(o_wr_resp_error), .o_obj_index(o_obj_index),
    .o_obj_object_subindex(o_obj_object_subindex), .o_obj_rd(o_obj_rd), .o_obj_wr(o_obj_wr),
    .o_obj_wdata(o_obj_wdata), .i_obj_exists(i_obj_exists), .i_obj_access(i_obj_access),
    .i_obj_format(i_obj_format), .i_obj_rdata(i_obj_rdata), .o_ch_present(o_ch_present));
`default_nettype wire

/* File: oda_obj_store.sv */
// Purpose: behavioural object store answering the engine lookup port
// Assumes: combinational answer to the object address, writes on i_wr
// Notes: junk in the upper value bits makes alignment faults visible
`timescale 1ns/100ps
`default_nettype none
`include "oda_defines.vh"
module oda_obj_store (
    input wire logic i_clk,
    input wire logic [15:0] i_index,
    input wire logic [7:0] i_sub,
    input wire logic i_wr,
    input wire logic [31:0] i_wdata,
    output logic o_exists,
    output logic [1:0] o_access,
    output logic [1:0] o_format,
    output logic [31:0] o_rdata
);
    logic [31:0] rw_reg;
    logic [23:0] addr_reg;
    // the store pulse trails the lookup by a cycle, so keep that address
    always @(posedge i_clk) begin
        addr_reg <= {i_index, i_sub};
        if (i_wr && addr_reg == 24'h420004) begin
            rw_reg <= i_wdata;
        end
    end
    // lookup table; absent objects show a moving pattern, not a stale value
    always @* begin
        o_exists = 1'b1;
        o_access = `ODA_OBJ_RW;
        o_format = `ODA_FMT_32;
        o_rdata = ~{i_index, i_sub, i_index[7:0]};
        case ({i_index, i_sub})
            24'h420003: o_access = `ODA_OBJ_WO;
            24'h420004: o_rdata = rw_reg;
            24'h420005: begin
                o_access = `ODA_OBJ_RO;
                o_format = `ODA_FMT_8;
                o_rdata = 32'hFFFF_FFA5;
            end
            24'h427001: begin
                o_access = `ODA_OBJ_RO;
                o_format = `ODA_FMT_16;
                o_rdata = 32'h1234_BEEF;
            end
            24'h430001: o_format = `ODA_FMT_WIDE;
            default: begin
                if (i_index[15:8] == 8'h51) o_rdata = {16'h0000, i_index};
                else o_exists = 1'b0;
            end
        endcase
    end
endmodule // oda_obj_store
`default_nettype wire

/* File: oda_testbench.sv */
// Purpose: self-checking bench for the object dictionary access engine
// Assumes: 20 MHz clock, requests paced by single update pulses
// Notes: basic read cases run from a table; writes, follow-up reads and apb by hand
`timescale 1ns/100ps
`default_nettype none
`include "oda_defines.vh"
module testbench;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic cyc = 1'b0;
    logic [15:0] ri = 16'h0000, wi = 16'h0000;
    logic [7:0] rs = 8'h00, rf = 8'h00, ws = 8'h00, wf = 8'h00;
    logic [31:0] wv = 32'h0, pwd = 32'h0, rdat;
    logic [11:0] pa = 12'h000;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    wire [15:0] rri, wri, oi;
    wire [7:0] rrs, rre, wrs, wre, os;
    wire [31:0] rrv, owd, prd, srd;
    wire ord, owr, sex, prdy, irq, perr;
    wire [1:0] sac, sfm;
    wire [5:0] chp;
    int failures = 0, check_count = 0;
    // index, subindex, expected error, expected value
    logic [63:0] rows [0:6] = '{64'h4200_0500_0000_00A5, 64'h4270_0100_0000_BEEF,
        64'h4200_0301_0000_0000, 64'h4300_0102_0000_0000, 64'h4444_0104_0000_0000,
        64'h5101_0104_0000_0000, 64'h0000_0000_0000_0000};
    oda_engine #(.NUM_CH(6)) uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cyc_update(cyc),
        .i_rd_index(ri), .i_rd_object_subindex(rs), .i_rd_filler(rf), .i_wr_index(wi),
        .i_wr_object_subindex(ws), .i_wr_filler(wf), .i_wr_value(wv), .o_rd_resp_index(rri),
        .o_rd_resp_object_subindex(rrs), .o_rd_resp_error(rre), .o_rd_resp_value(rrv),
        .o_wr_resp_index(wri), .o_wr_resp_object_subindex(wrs), .o_wr_resp_error(wre),
        .o_obj_index(oi), .o_obj_object_subindex(os), .o_obj_rd(ord), .o_obj_wr(owr),
        .o_obj_wdata(owd), .i_obj_exists(sex), .i_obj_access(sac), .i_obj_format(sfm),
        .i_obj_rdata(srd), .o_ch_present(chp), .i_paddr(pa), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
        .o_irq(irq));
    oda_obj_store store (.i_clk(i_clk), .i_index(oi), .i_sub(os), .i_wr(owr), .i_wdata(owd),
        .o_exists(sex), .o_access(sac), .o_format(sfm), .o_rdata(srd));
    // free-running clock
    always #25 i_clk = ~i_clk;
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s exp %h seen %h", n, e, s);
        end
    endtask
    // one cyclic refresh, then wait past the two-edge answer
    task rq(input bit w, input [15:0] x, input [7:0] s, input [7:0] f, input [31:0] v);
        @(posedge i_clk);
        if (w) {wi, ws, wf, wv} <= {x, s, f, v};
        else {ri, rs, rf} <= {x, s, f};
        cyc <= 1'b1;
        @(posedge i_clk);
        cyc <= 1'b0;
        repeat (3) @(posedge i_clk);
        #1;
    endtask
    // index parked at zero while subindex and value load
    task wr(input [15:0] x, input [7:0] s, input [31:0] v, input [7:0] e);
        rq(1'b1, 16'h0000, s, 8'h00, v);
        rq(1'b1, x, s, 8'h00, v);
        chk("wr index", {wri, wrs}, {x, s});
        chk("wr error", {24'h0, wre}, {24'h0, e});
    endtask
    task apb(input bit w, input [11:0] a, input [31:0] d, output [31:0] r);
        @(posedge i_clk);
        {psel, pen, pwr, pa, pwd} <= {1'b1, 1'b0, w, a, d};
        @(posedge i_clk);
        pen <= 1'b1;
        @(posedge i_clk);
        while (prdy !== 1'b1) @(posedge i_clk);
        r = prd;
        chk("pslverr", {31'h0, perr}, 32'h0);
        {psel, pen} <= 2'b00;
    endtask
    task finish_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        repeat (3000) @(posedge i_clk);
        failures++;
        finish_test;
    end
    initial begin
        repeat (5) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        for (int k = 0; k < 7; k++) begin
            rq(1'b0, rows[k][63:48], rows[k][47:40], 8'h00, 32'h0);
            chk("rd echo", {rri, rrs}, {rows[k][63:48], rows[k][47:40]});
            chk("rd error", {24'h0, rre}, {24'h0, rows[k][39:32]});
            chk("rd value", rrv, rows[k][31:0]);
        end
        wr(16'h4200, 8'h04, 32'h3F80_0000, 8'h00);
        rq(1'b0, 16'h4200, 8'h04, 8'h00, 32'h0);
        chk("float", rrv, 32'h3F80_0000);
        wr(16'h4200, 8'h04, 32'hFFFF_FFFF, 8'h00);
        rq(1'b0, 16'h4200, 8'h04, 8'h00, 32'h0);
        chk("unchanged", rrv, 32'h3F80_0000);
        rq(1'b0, 16'h4200, 8'h04, 8'h01, 32'h0);
        chk("filler", rrv, 32'hFFFF_FFFF);
        wr(16'h4200, 8'h05, 32'h0000_0007, 8'h01);
        wr(16'h4200, 8'h03, 32'h0000_0000, 8'h00);
        wr(16'h5001, 8'h01, 32'h0000_0003, 8'h00);
        wr(16'h5001, 8'h02, 32'h0000_0001, 8'h00);
        chk("channels", {26'h0, chp}, 32'h0000_0003);
        rq(1'b0, 16'h5102, 8'h01, 8'h00, 32'h0);
        chk("dynamic", {rre, rrv[23:0]}, 32'h0000_5102);
        wr(16'h5001, 8'h01, 32'h0000_0000, 8'h00);
        rq(1'b0, 16'h5101, 8'h01, 8'h02, 32'h0);
        chk("removed", {24'h0, rre}, 32'h0000_0004);
        apb(1'b0, `ODA_A_STATUS, 32'h0, rdat);
        chk("status", rdat, 32'h0000_000F);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, `ODA_A_ENABLE, 32'h0000_0004, rdat);
        @(posedge i_clk);
        #1;
        chk("irq on", {31'h0, irq}, 32'h1);
        apb(1'b1, `ODA_A_CLEAR, 32'h0000_0004, rdat);
        @(posedge i_clk);
        #1;
        chk("irq off", {31'h0, irq}, 32'h0);
        apb(1'b0, `ODA_A_STATUS, 32'h0, rdat);
        chk("status cleared", rdat, 32'h0000_000B);
        apb(1'b0, `ODA_A_CHMAP, 32'h0, rdat);
        chk("chmap", rdat, 32'h0000_0002);
        apb(1'b0, 12'h020, 32'h0, rdat);
        chk("unmapped", rdat, 32'h0);
        i_sys_rst <= 1'b1;
        repeat (5) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        #1;
        chk("reset", {rri, 10'h0, chp}, 32'h0);
        finish_test;
    end
endmodule // testbench
`default_nettype wire
